// >>> inc/mafp_pkg.sv
// package of constants, types and register map for the memory attribute fault policy
package mafp_pkg;

	// wishbone register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] CNT_OFS = 8'h08;

	// control register field positions
	localparam int TRAP_MISALIGNED_BIT = 0;
	localparam int DATA_CACHE_ENABLE_BIT = 1;
	localparam int INSTR_CACHE_ENABLE_BIT = 2;
	localparam int DATA_CACHE_ACTIVE_BIT = 3;
	localparam int INSTR_CACHE_ACTIVE_BIT = 4;
	localparam int SECURE_DEBUG_ENABLE_BIT = 5;
	localparam int CTRL_WIDTH = 6;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;

	// status register field positions
	localparam int ST_SECURE_BIT = 0;
	localparam int ST_UNALIGNED_BIT = 1;
	localparam int ST_NO_COPROCESSOR_FAULT_BIT = 2;
	localparam int ST_DBGERR_BIT = 3;
	localparam int ST_BUSERR_BIT = 4;
	localparam int STAT_WIDTH = 5;
	localparam logic [STAT_WIDTH-1:0] STAT_RESET = 5'h00;

	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// number of tightly coupled memory ports
	localparam int TCM_PORTS = 5;

	// access size codes (bytes = 1 << size)
	typedef enum logic [1:0] {
		SZ_BYTE,
		SZ_HALF,
		SZ_WORD,
		SZ_DWORD
	} mafp_size_t;

	// requesting source
	typedef enum logic [1:0] {
		SRC_LOAD_STORE,
		SRC_FETCH,
		SRC_DEBUG
	} mafp_source_t;

	// target interface chosen for the access
	typedef enum logic [2:0] {
		TGT_AXI,
		TGT_PERIPH_AHB,
		TGT_PERIPH_APB,
		TGT_TCM,
		TGT_NONE
	} mafp_target_t;

	// wishbone slave state
	typedef enum logic [1:0] {
		WB_IDLE,
		WB_ACK
	} mafp_wbstate_t;

endpackage : mafp_pkg

// >>> hw/mafp_policy.sv
// memory attribute fault policy: classifies accesses, raises faults
`timescale 1ns/100ps
//
// Overview of operation
// - failed security attribution of non-debug, non-speculative access raises security fault
// - debug security state uses same attribution
// - blocked secure debug access gives bus error
// - trap enable faults any unaligned non-debug, non-speculative access
// - unaligned device or unsupported instruction faults
// - vector access misaligned to element faults
// - absent coprocessor raises no-coprocessor fault
// - only normal cacheable memory is cached
// - data shareable uncached; cache needs enable, active
// - fetch cached regardless of shareability; needs enable, active
// - every axi store goes through store buffer
// - only shareable exclusives marked exclusive on bus
// - non-shared uses internal monitor; shared both
// - only normal memory is restartable
// - merge normal; device only for vector micro-ops
// - vector device accesses may combine per micro-op
// - speculative tcm reads may use any port
// - no speculative xn fetch on axi, non-cacheable linefill
// - no speculative reads or linefills to device
// - no speculative peripheral reads, no speculative writes
// - tcm addresses always treated as normal
// - speculative error responses discarded without fault
module mafp_policy
	import mafp_pkg::*;
#(
	parameter int ADDR_WIDTH = 32,
	parameter int CNT_WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAck,
	// access request
	input wire logic reqValid,
	input wire mafp_pkg::mafp_source_t reqSource,
	input wire logic reqWrite,
	input wire logic [ADDR_WIDTH-1:0] reqAddr,
	input wire mafp_pkg::mafp_size_t reqSize,
	input wire logic reqDevice,
	input wire logic reqShareable,
	input wire logic reqCacheable,
	input wire logic reqExecNever,
	input wire logic reqExclusive,
	input wire logic reqSpeculative,
	input wire logic reqLinefill,
	input wire logic reqVector,
	input wire mafp_pkg::mafp_size_t reqElemSize,
	input wire logic reqNoUnalignInstr,
	input wire logic reqCoproc,
	input wire logic coprocPresent,
	input wire logic reqTcmHit,
	input wire logic reqPeriphAhb,
	input wire logic reqPeriphApb,
	// attribution result from the security attribution logic
	input wire logic attrSecure,
	input wire logic attrFail,
	input wire logic debugAhbNonsecure,
	// bus error response returning for an earlier access
	input wire logic busErrValid,
	input wire logic busErrSpeculative,
	// decided access
	output logic accValid,
	output mafp_pkg::mafp_target_t accTarget,
	output logic accNonsecure,
	output logic accCacheable,
	output logic accExclMark,
	output logic accExtMonitor,
	output logic accIntMonitor,
	output logic accViaStoreBuffer,
	output logic accMergeable,
	output logic accRestartable,
	output logic accAnyTcmPort,
	output logic accSuppressed,
	// fault pulses
	output logic secureFault,
	output logic unalignedFault,
	output logic noCoprocFault,
	output logic debugBusError,
	output logic busFault
);

	////////////////////////////////////////////////////////////////////////
	// combinational classification

	logic [CTRL_WIDTH-1:0] ctrl_reg;
	logic [STAT_WIDTH-1:0] stat_reg;
	logic [CNT_WIDTH-1:0] suppCnt_reg;
	mafp_wbstate_t wbState_reg;

	logic isNormal;
	logic isDebug;
	logic misaligned;
	logic vecMisaligned;
	logic secFault;
	logic dbgBlock;
	logic alignFault;
	logic cpFault;
	logic anyFault;
	logic cacheOk;
	logic specBlock;
	mafp_target_t target;

	function automatic logic misalignedFor(
		input logic [2:0] low,
		input mafp_size_t sz
	);
		case (sz)
			SZ_BYTE: misalignedFor = 1'b0;
			SZ_HALF: misalignedFor = low[0];
			SZ_WORD: misalignedFor = |low[1:0];
			SZ_DWORD: misalignedFor = |low;
			default: misalignedFor = 1'b0;
		endcase
	endfunction : misalignedFor

	// tightly coupled memory always counts as normal
	assign isNormal = reqTcmHit | ~reqDevice;
	assign isDebug = (reqSource == SRC_DEBUG);
	assign misaligned = misalignedFor(reqAddr[2:0], reqSize);
	assign vecMisaligned = reqVector &
		misalignedFor(reqAddr[2:0], reqElemSize);

	// debugger blocked on secure memory without secure debug
	assign dbgBlock = isDebug & attrSecure &
		(~ctrl_reg[SECURE_DEBUG_ENABLE_BIT] | debugAhbNonsecure);
	assign secFault = attrFail & ~isDebug & ~reqSpeculative;
	assign alignFault = ~isDebug & ~reqSpeculative & (vecMisaligned |
		(misaligned & (ctrl_reg[TRAP_MISALIGNED_BIT] |
		~isNormal | reqNoUnalignInstr)));
	assign cpFault = reqCoproc & ~coprocPresent;
	assign anyFault = secFault | alignFault | cpFault | dbgBlock |
		(attrFail & isDebug);

	always_comb begin
		if (reqTcmHit)
			target = TGT_TCM;
		else if (reqPeriphApb)
			target = TGT_PERIPH_APB;
		else if (reqPeriphAhb)
			target = TGT_PERIPH_AHB;
		else
			target = TGT_AXI;
	end

	// cache eligibility per side
	always_comb begin
		if (!isNormal || !reqCacheable || target != TGT_AXI)
			cacheOk = 1'b0;
		else if (reqSource == SRC_FETCH)
			cacheOk = ctrl_reg[INSTR_CACHE_ENABLE_BIT] &
				ctrl_reg[INSTR_CACHE_ACTIVE_BIT];
		else
			cacheOk = ~reqShareable & ctrl_reg[DATA_CACHE_ENABLE_BIT] &
				ctrl_reg[DATA_CACHE_ACTIVE_BIT];
	end

	// speculation limits
	always_comb begin
		specBlock = 1'b0;
		if (reqSpeculative) begin
			if (reqWrite)
				specBlock = 1'b1;
			else if (target == TGT_PERIPH_AHB || target == TGT_PERIPH_APB)
				specBlock = 1'b1;
			else if (!isNormal)
				specBlock = 1'b1;
			else if (reqSource == SRC_FETCH && reqExecNever &&
				target == TGT_AXI)
				specBlock = 1'b1;
			else if (reqLinefill && !cacheOk)
				specBlock = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered access decision

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			accValid <= 1'b0;
			accTarget <= TGT_NONE;
			accNonsecure <= 1'b0;
			accCacheable <= 1'b0;
			accExclMark <= 1'b0;
			accExtMonitor <= 1'b0;
			accIntMonitor <= 1'b0;
			accViaStoreBuffer <= 1'b0;
			accMergeable <= 1'b0;
			accRestartable <= 1'b0;
			accAnyTcmPort <= 1'b0;
			accSuppressed <= 1'b0;
		end else if (clkEn) begin
			accValid <= reqValid & ~anyFault & ~specBlock;
			accSuppressed <= reqValid & specBlock & ~anyFault;
			accTarget <= (reqValid & ~anyFault & ~specBlock) ? target : TGT_NONE;
			// same attribution for debug and software
			accNonsecure <= ~attrSecure;
			accCacheable <= cacheOk;
			accExclMark <= reqExclusive & reqShareable &
				(target == TGT_AXI || target == TGT_PERIPH_AHB);
			accIntMonitor <= reqExclusive;
			accExtMonitor <= reqExclusive & reqShareable;
			accViaStoreBuffer <= reqWrite & (target == TGT_AXI);
			// device merges only for vector micro-ops
			accMergeable <= isNormal | reqVector;
			accRestartable <= isNormal;
			accAnyTcmPort <= reqSpeculative & ~reqWrite & reqTcmHit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fault pulses

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secureFault <= 1'b0;
			unalignedFault <= 1'b0;
			noCoprocFault <= 1'b0;
			debugBusError <= 1'b0;
			busFault <= 1'b0;
		end else if (clkEn) begin
			secureFault <= reqValid & secFault;
			unalignedFault <= reqValid & alignFault & ~secFault;
			noCoprocFault <= reqValid & cpFault;
			debugBusError <= reqValid & isDebug & (dbgBlock | attrFail);
			busFault <= busErrValid & ~busErrSpeculative;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone register file

	logic wbHit;
	logic [31:0] rdData;

	assign wbHit = wbCyc & wbStb & (wbState_reg == WB_IDLE);

	always_comb begin
		case (wbAdr)
			CTRL_OFS: rdData = {{(32-CTRL_WIDTH){1'b0}}, ctrl_reg};
			STAT_OFS: rdData = {{(32-STAT_WIDTH){1'b0}}, stat_reg};
			CNT_OFS: rdData = {{(32-CNT_WIDTH){1'b0}}, suppCnt_reg};
			default: rdData = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wbState_reg <= WB_IDLE;
			wbAck <= 1'b0;
			wbDatO <= UNMAPPED_READ;
		end else if (clkEn) begin
			case (wbState_reg)
				WB_IDLE: begin
					if (wbHit) begin
						wbAck <= 1'b1;
						wbDatO <= rdData;
						wbState_reg <= WB_ACK;
					end
				end
				WB_ACK: begin
					wbAck <= 1'b0;
					wbState_reg <= WB_IDLE;
				end
				default: begin
					wbAck <= 1'b0;
					wbState_reg <= WB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ctrl_reg <= CTRL_RESET;
		else if (clkEn && wbHit && wbWe && wbAdr == CTRL_OFS && wbSel[0])
			ctrl_reg <= wbDatI[CTRL_WIDTH-1:0];
	end

	// sticky fault status; write one to clear, a new event wins
	logic [STAT_WIDTH-1:0] statSet;
	logic [STAT_WIDTH-1:0] statClr;

	always_comb begin
		statSet = '0;
		statSet[ST_SECURE_BIT] = reqValid & secFault;
		statSet[ST_UNALIGNED_BIT] = reqValid & alignFault;
		statSet[ST_NO_COPROCESSOR_FAULT_BIT] = reqValid & cpFault;
		statSet[ST_DBGERR_BIT] = reqValid & isDebug & (dbgBlock | attrFail);
		statSet[ST_BUSERR_BIT] = busErrValid & ~busErrSpeculative;
		statClr = '0;
		if (wbHit && wbWe && wbAdr == STAT_OFS && wbSel[0])
			statClr = wbDatI[STAT_WIDTH-1:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			stat_reg <= STAT_RESET;
		else if (clkEn)
			stat_reg <= (stat_reg & ~statClr) | statSet;
	end

	// count of suppressed speculative requests, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			suppCnt_reg <= '0;
		else if (clkEn && reqValid && specBlock && !anyFault &&
			suppCnt_reg != {CNT_WIDTH{1'b1}})
			suppCnt_reg <= suppCnt_reg + 1'b1;
	end

endmodule : mafp_policy

// >>> test/mafp_policy_props.sv
// assertions on the memory attribute fault policy ports
`timescale 1ns/100ps
module mafp_policy_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire mafp_pkg::mafp_source_t reqSource,
	input wire logic reqWrite,
	input wire logic reqDevice,
	input wire logic reqShareable,
	input wire logic reqExclusive,
	input wire logic reqSpeculative,
	input wire logic reqTcmHit,
	input wire logic reqVector,
	input wire logic accNonsecure,
	input wire logic accExtMonitor,
	input wire logic accIntMonitor,
	input wire logic accMergeable,
	input wire logic accAnyTcmPort,
	input wire logic attrSecure,
	input wire logic attrFail,
	input wire logic debugAhbNonsecure,
	input wire logic busErrValid,
	input wire logic busErrSpeculative,
	input wire logic accValid,
	input wire mafp_pkg::mafp_target_t accTarget,
	input wire logic accCacheable,
	input wire logic accExclMark,
	input wire logic accViaStoreBuffer,
	input wire logic accRestartable,
	input wire logic accSuppressed,
	input wire logic secureFault,
	input wire logic debugBusError,
	input wire logic busFault
);
	import mafp_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence sReq(c);
		clkEn && reqValid && c;
	endsequence
	sequence sSpecErr;
		busErrValid && busErrSpeculative;
	endsequence
	////////////////////////////////////////////////////////////////////////
	AST_SECURE_FAULT: assert property (
		sReq(attrFail && reqSource != SRC_DEBUG && !reqSpeculative)
		|=> secureFault && !accValid) else $error("secure fault missing");
	AST_DEBUG_BLOCK: assert property (
		sReq(reqSource == SRC_DEBUG && attrSecure && debugAhbNonsecure)
		|=> debugBusError && !secureFault && !accValid)
		else $error("debug block wrong");
	AST_DEVICE_PLAIN: assert property (
		sReq(reqDevice && !reqTcmHit) |=> !accCacheable && !accRestartable)
		else $error("device access cached or restartable");
	AST_SHARE_UNCACHED: assert property (
		sReq(reqSource == SRC_LOAD_STORE && reqShareable) |=> !accCacheable)
		else $error("shareable data cached");
	AST_EXCL_MARK: assert property (
		accValid && $past(reqExclusive)
		&& accTarget inside {TGT_AXI, TGT_PERIPH_AHB}
		|-> accExclMark == $past(reqShareable)) else $error("exclusive mark");
	AST_STORE_BUFFER: assert property (
		accValid && accTarget == TGT_AXI && $past(reqWrite)
		|-> accViaStoreBuffer) else $error("store bypassed buffer");
	AST_SPEC_BLOCK: assert property (
		sReq(reqSpeculative && (reqWrite || reqDevice && !reqTcmHit))
		|=> accSuppressed && !accValid) else $error("speculation issued");
	AST_SPEC_ERROR: assert property (
		sSpecErr |=> !busFault) else $error("speculative error faulted");
	AST_NONSECURE: assert property (
		sReq(1'b1) |=> accNonsecure == !$past(attrSecure))
		else $error("security state not from attribution");
	AST_MONITORS: assert property (
		sReq(reqExclusive)
		|=> accIntMonitor && accExtMonitor == $past(reqShareable))
		else $error("exclusive monitor choice wrong");
	AST_TCM_SPEC: assert property (
		sReq(reqTcmHit && reqSpeculative && !reqWrite)
		|=> accAnyTcmPort && accRestartable)
		else $error("tcm speculative read restricted");
	AST_DEVICE_MERGE: assert property (
		sReq(reqDevice && !reqTcmHit && !reqVector) |=> !accMergeable)
		else $error("device access mergeable");
endmodule : mafp_policy_props
bind mafp_policy mafp_policy_props u_props (.*);

// >>> test/mafp_bus_model.sv
// far-side bus model returning error responses for issued accesses
`timescale 1ns/100ps
module mafp_bus_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic accValid,
	input wire logic errReq,
	input wire logic errSpec,
	output logic busErrValid,
	output logic busErrSpeculative
);
	// one response per access issued while errReq is high, never combined with another
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busErrValid <= 1'h0;
			busErrSpeculative <= 1'h0;
		end else begin
			busErrValid <= accValid && errReq;
			// flag means nothing outside a response, so it keeps moving
			busErrSpeculative <= (accValid && errReq) ? errSpec
				: ~busErrSpeculative;
		end
	end
endmodule : mafp_bus_model

// >>> test/test_mafp_policy.sv
// self-checking bench for the memory attribute fault policy
`timescale 1ns/100ps
module test_mafp_policy;
	import mafp_pkg::*;
	typedef struct packed {logic [23:0] stim; logic [7:0] want;} mafp_row_t;
	logic clk, rst, clkEn, wbCyc, wbStb, wbWe, wbAck, reqValid, reqWrite;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatI, wbDatO, reqAddr, rd;
	mafp_source_t reqSource;
	mafp_size_t reqSize, reqElemSize;
	mafp_target_t accTarget;
	logic reqDevice, reqShareable, reqCacheable, reqExecNever, reqExclusive;
	logic reqSpeculative, reqLinefill, reqVector, reqNoUnalignInstr, reqCoproc;
	logic coprocPresent, reqTcmHit, reqPeriphAhb, reqPeriphApb, attrSecure;
	logic attrFail, debugAhbNonsecure, busErrValid, busErrSpeculative, errReq;
	logic errSpec, accValid, accNonsecure, accCacheable, accExclMark;
	logic accExtMonitor, accIntMonitor, accViaStoreBuffer, accMergeable;
	logic accRestartable, accAnyTcmPort, accSuppressed, secureFault;
	logic unalignedFault, noCoprocFault, debugBusError, busFault;
	int badCount = 0;
	int checked = 0;
	// stim: vec noUnal ahb apb xn fill src dev sh cach spec wr excl a0 size
	// tcm fail coproc secure dbgNonsec; want: dbgErr valid cach excl sec
	// unal no_coprocessor_fault suppressed
	mafp_row_t rows [20] = '{
		'{24'h000840, 8'h60},
		'{24'h001840, 8'h40},
		'{24'h005840, 8'h60},
		'{24'h002040, 8'h40},
		'{24'h001140, 8'h50},
		'{24'h000140, 8'h40},
		'{24'h000048, 8'h08},
		'{24'h0020C0, 8'h04},
		'{24'h0000C0, 8'h40},
		'{24'h000044, 8'h02},
		'{24'h000640, 8'h01},
		'{24'h002440, 8'h01},
		'{24'h000450, 8'h40},
		'{24'h008043, 8'h80},
		'{24'h200080, 8'h04},
		'{24'h1000C0, 8'h04},
		'{24'h080440, 8'h01},
		'{24'h024440, 8'h01},
		'{24'h010440, 8'h01},
		'{24'h000240, 8'h40}
	};
	mafp_policy u_dut (.*);
	mafp_bus_model u_bus (.*);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x) begin
			$display("BAD %s expected %h seen %h", n, x, g);
			badCount++;
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{wbCyc, wbStb, wbWe} <= {2'h3, w};
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'h1 && n < 20);
		rd = wbDatO;
		{wbCyc, wbStb} <= 2'h0;
		if (n >= 20) badCount++;
	endtask : wb
	task automatic do_req(input logic [23:0] i, input logic [7:0] e);
		@(posedge clk);
		reqValid <= 1'h1;
		{reqVector, reqNoUnalignInstr, reqPeriphAhb} <= i[21:19];
		{reqPeriphApb, reqExecNever, reqLinefill} <= i[18:16];
		reqSource <= mafp_source_t'(i[15:14]);
		{reqDevice, reqShareable, reqCacheable} <= i[13:11];
		{reqSpeculative, reqWrite, reqExclusive} <= i[10:8];
		reqAddr <= {24'h000001, 7'h00, i[7]};
		reqSize <= mafp_size_t'(i[6:5]);
		{reqTcmHit, attrFail, reqCoproc, attrSecure} <= i[4:1];
		debugAhbNonsecure <= i[0];
		coprocPresent <= ~i[2];
		@(posedge clk);
		reqValid <= 1'h0;
		#1;
		chk("result", {24'h0, e}, {24'h0, debugBusError, accValid, accCacheable,
			accExclMark, secureFault, unalignedFault, noCoprocFault,
			accSuppressed});
	endtask : do_req
	task automatic berr(input logic s, input logic x);
		logic hit;
		hit = 1'h0;
		errReq <= 1'h1;
		errSpec <= s;
		do_req(24'h000840, 8'h60);
		@(posedge clk);
		errReq <= 1'h0;
		repeat (4) @(posedge clk) hit |= busFault;
		chk("busFault", {31'h0, x}, {31'h0, hit});
	endtask : berr
	task test_done;
		$display("checked %0d bad %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		badCount++;
		test_done();
	end
	initial begin
		rst = 1'h1;
		clkEn = 1'h1;
		wbSel = 4'hF;
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI, reqValid, reqAddr} = '0;
		reqSource = SRC_LOAD_STORE;
		reqSize = SZ_WORD;
		reqElemSize = SZ_WORD;
		{reqWrite, reqDevice, reqShareable, reqCacheable, reqExecNever} = '0;
		{reqExclusive, reqSpeculative, reqLinefill, reqVector} = '0;
		{reqNoUnalignInstr, reqCoproc, reqTcmHit, reqPeriphAhb} = '0;
		{reqPeriphApb, attrSecure, attrFail, debugAhbNonsecure} = '0;
		{errReq, errSpec} = '0;
		coprocPresent = 1'h1;
		repeat (12) @(posedge clk);
		#1;
		chk("reset", {26'h0, TGT_NONE, 3'h0},
			{26'h0, accTarget, accValid, secureFault, busFault});
		rst <= 1'h0;
		wb(1'h0, CTRL_OFS, 32'h0);
		chk("ctrl", {26'h0, CTRL_RESET}, rd);
		wb(1'h1, CTRL_OFS, 32'h1E);
		foreach (rows[k]) do_req(rows[k].stim, rows[k].want);
		wb(1'h1, CTRL_OFS, 32'h1F);
		do_req(24'h0000C0, 8'h04);
		berr(1'h0, 1'h1);
		berr(1'h1, 1'h0);
		wb(1'h0, STAT_OFS, 32'h0);
		chk("stat", 32'h1F, rd);
		wb(1'h1, STAT_OFS, 32'h1F);
		wb(1'h0, STAT_OFS, 32'h0);
		chk("statClear", 32'h0, rd);
		wb(1'h0, CNT_OFS, 32'h0);
		chk("count", 32'h5, rd);
		wb(1'h1, 8'hF0, 32'hFFFFFFFF);
		wb(1'h0, 8'hF0, 32'h0);
		chk("unmapped", UNMAPPED_READ, rd);
		test_done();
	end
endmodule : test_mafp_policy
